/* File: hdl/mpks_defines.vh */
// Purpose: constants for the module power key sequencer
// Assumes: 100 MHz clk_sys
// Notes:   times kept in their own unit, cycle counts derived
`ifndef MPKS_DEFINES_VH
`define MPKS_DEFINES_VH
`define MPKS_CLK_MHZ        100
`define MPKS_ON_MIN_S       1
`define MPKS_OFF_MIN_S      2
`define MPKS_RST_MIN_MS     200
`define MPKS_ON_CYC         (`MPKS_ON_MIN_S * 1000000 * `MPKS_CLK_MHZ)
`define MPKS_OFF_CYC        (`MPKS_OFF_MIN_S * 1000000 * `MPKS_CLK_MHZ)
`define MPKS_RST_CYC        (`MPKS_RST_MIN_MS * 1000 * `MPKS_CLK_MHZ)
`define MPKS_BOOT_CYC       1000
`define MPKS_DETACH_CYC     1000
`define MPKS_CNT_W          32
`define MPKS_LVL_W          3
`define MPKS_LVL_SLEEP      3'h0
`define MPKS_LVL_FULL       3'h1
`define MPKS_LVL_NORF       3'h4
`define MPKS_LVL_SAVE       3'h5
`endif

/* File: hdl/mpks_low_timer.v */
// Purpose: measures how long an active-low line has been held low
// Assumes: line synchronous to clk_sys
// Notes:   count saturates once the threshold is reached
`timescale 1ns/1ps
`include "mpks_defines.vh"
module mpks_low_timer #(
    parameter [`MPKS_CNT_W-1:0] THRESH = 32'h00000001
) (
    // clock and reset
    input  wire                   clk_sys,
    input  wire                   rstn,
    // line in
    input  wire                   lineLevel,
    // result
    output wire                   heldLong
);
    reg [`MPKS_CNT_W-1:0] count_reg;
    reg [`MPKS_CNT_W-1:0] count_next;

    always @* begin
        if (lineLevel)
            count_next = {`MPKS_CNT_W{1'b0}};
        else if (count_reg < THRESH)
            count_next = count_reg + 32'h00000001;
        else
            count_next = count_reg;
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            count_reg <= {`MPKS_CNT_W{1'b0}};
        else
            count_reg <= count_next;
    end

    assign heldLong = (count_reg >= THRESH);
endmodule

/* File: hdl/mpks_module_power_key_sequencer.v */
// Purpose: power on/off/restart sequencing inside the modem module
// Assumes: key and restart pins synchronous to clk_sys, pulled high
// Notes:   timing counts are parameters so simulation can shorten them
//
// Functional notes
// - key line pulled up internally, reads high
// - off by software or key; restart reboots without going off
// - software or key off sends detach first
// - key-off shutdown starts only after key release; software off starts at once
// - monitor goes low once powered off
// - levels 1 full, 4 no rf, 5 saving
`timescale 1ns/1ps
`include "mpks_defines.vh"
module mpks_module_power_key_sequencer #(
    parameter [`MPKS_CNT_W-1:0] ON_CYC     = `MPKS_ON_CYC,
    parameter [`MPKS_CNT_W-1:0] OFF_CYC    = `MPKS_OFF_CYC,
    parameter [`MPKS_CNT_W-1:0] RST_CYC    = `MPKS_RST_CYC,
    parameter [`MPKS_CNT_W-1:0] BOOT_CYC   = `MPKS_BOOT_CYC,
    parameter [`MPKS_CNT_W-1:0] DETACH_CYC = `MPKS_DETACH_CYC
) (
    // clock and reset
    input  wire                   clk_sys,
    input  wire                   rstn,
    // power key pin, resolved level with pull-up
    input  wire                   powerKeyN,
    output wire                   powerKeyOut,
    output wire                   powerKeyOeN,
    // restart pin, resolved level with pull-up
    input  wire                   restartN,
    // software side
    input  wire                   swOffReq,
    input  wire                   levelWrite,
    input  wire [`MPKS_LVL_W-1:0] levelValue,
    input  wire                   wakeEvent,
    input  wire                   rtsLine,
    // status
    output reg                    power_state_monitor,
    output reg                    detachReq,
    output reg                    rfEnable,
    output reg                    registered,
    output reg                    powerSave,
    output reg                    cmdAccept,
    output reg  [`MPKS_LVL_W-1:0] function_level_setting
);
    localparam [4:0] ST_OFF    = 5'h01;
    localparam [4:0] ST_BOOT   = 5'h02;
    localparam [4:0] ST_ON     = 5'h04;
    localparam [4:0] ST_ARMED  = 5'h08;
    localparam [4:0] ST_DETACH = 5'h10;

    // pin never driven: internal pull-up keeps it high
    assign powerKeyOut = 1'b1;
    assign powerKeyOeN = 1'b1;

    wire onHeld;
    wire offHeld;
    wire rstHeld;

    mpks_low_timer #(.THRESH(ON_CYC)) uOnTimer (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .lineLevel (powerKeyN),
        .heldLong  (onHeld)
    );
    mpks_low_timer #(.THRESH(OFF_CYC)) uOffTimer (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .lineLevel (powerKeyN),
        .heldLong  (offHeld)
    );
    mpks_low_timer #(.THRESH(RST_CYC)) uRstTimer (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .lineLevel (restartN),
        .heldLong  (rstHeld)
    );

    reg [4:0]             state_reg;
    reg [4:0]             state_next;
    reg [`MPKS_CNT_W-1:0] cnt_reg;
    reg [`MPKS_CNT_W-1:0] cnt_next;
    reg                   onSeen_reg;
    reg                   onSeen_next;
    reg                   rstSeen_reg;
    reg                   rstSeen_next;
    reg                   keyPrev_reg;
    reg                   rstPrev_reg;
    reg                   rtsPrev_reg;
    reg [`MPKS_LVL_W-1:0] level_reg;
    reg [`MPKS_LVL_W-1:0] level_next;

    wire keyRise = powerKeyN & ~keyPrev_reg;
    wire rstRise = restartN & ~rstPrev_reg;
    wire rtsRise = rtsLine & ~rtsPrev_reg;
    wire sleeping = (level_reg == `MPKS_LVL_SLEEP);

    // armed keeps the module fully up until the key is released
    wire liveNext = (state_next == ST_ON) || (state_next == ST_ARMED);

    function isLegalLevel;
        input [`MPKS_LVL_W-1:0] lv;
        begin
            isLegalLevel = (lv == `MPKS_LVL_SLEEP) || (lv == `MPKS_LVL_FULL) ||
                           (lv == `MPKS_LVL_NORF) || (lv == `MPKS_LVL_SAVE);
        end
    endfunction

    always @* begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        onSeen_next  = onSeen_reg | onHeld;
        rstSeen_next = rstSeen_reg | rstHeld;
        level_next   = level_reg;
        if (rstSeen_reg && rstRise) begin
            rstSeen_next = 1'b0;
            onSeen_next  = 1'b0;
            cnt_next     = {`MPKS_CNT_W{1'b0}};
            level_next   = `MPKS_LVL_FULL;
            state_next   = ST_BOOT;
        end else begin
            case (state_reg)
            ST_OFF: begin
                if (onSeen_reg && keyRise) begin
                    onSeen_next = 1'b0;
                    cnt_next    = {`MPKS_CNT_W{1'b0}};
                    level_next  = `MPKS_LVL_FULL;
                    state_next  = ST_BOOT;
                end
            end
            ST_BOOT: begin
                onSeen_next = 1'b0;
                cnt_next    = cnt_reg + 32'h00000001;
                if (cnt_reg >= BOOT_CYC - 32'h00000001)
                    state_next = ST_ON;
            end
            ST_ON: begin
                if (offHeld)
                    state_next = ST_ARMED;
                else if (swOffReq && !sleeping) begin
                    cnt_next   = {`MPKS_CNT_W{1'b0}};
                    state_next = ST_DETACH;
                end else if (levelWrite && !sleeping && isLegalLevel(levelValue))
                    level_next = levelValue;
                else if (sleeping && (wakeEvent || rtsRise))
                    level_next = `MPKS_LVL_FULL;
            end
            ST_ARMED: begin
                if (keyRise) begin
                    cnt_next   = {`MPKS_CNT_W{1'b0}};
                    state_next = ST_DETACH;
                end
            end
            ST_DETACH: begin
                onSeen_next = 1'b0;
                cnt_next    = cnt_reg + 32'h00000001;
                if (cnt_reg >= DETACH_CYC - 32'h00000001)
                    state_next = ST_OFF;
            end
            default: state_next = ST_OFF;
            endcase
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg   <= ST_OFF;
            cnt_reg     <= {`MPKS_CNT_W{1'b0}};
            onSeen_reg  <= 1'b0;
            rstSeen_reg <= 1'b0;
            keyPrev_reg <= 1'b1;
            rstPrev_reg <= 1'b1;
            rtsPrev_reg <= 1'b0;
            level_reg   <= `MPKS_LVL_FULL;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            onSeen_reg  <= onSeen_next;
            rstSeen_reg <= rstSeen_next;
            keyPrev_reg <= powerKeyN;
            rstPrev_reg <= restartN;
            rtsPrev_reg <= rtsLine;
            level_reg   <= level_next;
        end
    end

    // registered status outputs
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            power_state_monitor    <= 1'b0;
            detachReq              <= 1'b0;
            rfEnable               <= 1'b0;
            registered             <= 1'b0;
            powerSave              <= 1'b0;
            cmdAccept              <= 1'b0;
            function_level_setting <= `MPKS_LVL_FULL;
        end else begin
            power_state_monitor    <= (state_next != ST_OFF);
            detachReq              <= (state_next == ST_DETACH);
            // radio and commands stay up while a held key is armed
            rfEnable               <= liveNext &&
                                      (level_next != `MPKS_LVL_NORF);
            registered             <= liveNext &&
                                      (level_next != `MPKS_LVL_NORF);
            powerSave              <= liveNext &&
                                      ((level_next == `MPKS_LVL_SAVE) ||
                                       (level_next == `MPKS_LVL_SLEEP));
            cmdAccept              <= liveNext &&
                                      (level_next != `MPKS_LVL_SLEEP);
            function_level_setting <= level_next;
        end
    end
endmodule

/* File: tb/mpks_checker.sv */
// Purpose: port assertions for the power key sequencer
// Assumes: sim counts ON 20, OFF 40, RST 10, BOOT 5, DETACH 5
// Notes:   bound to the top module by name
`timescale 1ns/1ps
module mpks_checker #(
    parameter int BOOT_CYC   = 5,
    parameter int DETACH_CYC = 5
) (
    // clock and reset
    input wire logic       clk_sys,
    input wire logic       rstn,
    // pins and software side
    input wire logic       powerKeyN,
    input wire logic       powerKeyOut,
    input wire logic       powerKeyOeN,
    input wire logic       levelWrite,
    input wire logic       wakeEvent,
    input wire logic       rtsLine,
    // status
    input wire logic       power_state_monitor,
    input wire logic       detachReq,
    input wire logic       rfEnable,
    input wire logic       registered,
    input wire logic       powerSave,
    input wire logic       cmdAccept,
    input wire logic [2:0] function_level_setting
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_boot;
        !rfEnable ##(BOOT_CYC - 1) !rfEnable ##1 rfEnable;
    endsequence
    sequence s_detach;
        detachReq ##(DETACH_CYC - 1) detachReq ##1 !detachReq ##[0:1] !power_state_monitor;
    endsequence
    property p_key_float; powerKeyOeN && powerKeyOut; endproperty
    a_key_float: assert property (p_key_float) else $error("key pin driven");
    property p_boot; $rose(power_state_monitor) |-> s_boot; endproperty
    a_boot: assert property (p_boot) else $error("boot length wrong");
    property p_detach; $rose(detachReq) |-> s_detach; endproperty
    a_detach: assert property (p_detach) else $error("detach phase wrong");
    property p_det_on; detachReq |-> power_state_monitor && !rfEnable; endproperty
    a_det_on: assert property (p_det_on) else $error("detach while off");
    property p_release; $rose(detachReq) |-> powerKeyN; endproperty
    a_release: assert property (p_release) else $error("off while key held");
    property p_lvl4;
        function_level_setting == 3'h4 && $stable(function_level_setting)
            |-> !rfEnable && !registered;
    endproperty
    a_lvl4: assert property (p_lvl4) else $error("radio on at level 4");
    property p_lvl5;
        function_level_setting == 3'h5 && $stable(function_level_setting) && cmdAccept
            |-> powerSave && registered;
    endproperty
    a_lvl5: assert property (p_lvl5) else $error("level 5 not saving");
    property p_lvl0;
        function_level_setting == 3'h0 && levelWrite && !wakeEvent && !rtsLine
            |=> function_level_setting == 3'h0 && !cmdAccept;
    endproperty
    a_lvl0: assert property (p_lvl0) else $error("level 0 took a command");
    property p_rts;
        function_level_setting == 3'h0 && $rose(rtsLine) |-> ##[1:2] function_level_setting == 3'h1;
    endproperty
    a_rts: assert property (p_rts) else $error("no wake on rts");
endmodule
bind mpks_module_power_key_sequencer mpks_checker mpks_checker_inst (.*);

/* File: tb/mpks_host_model.sv */
// Purpose: host open-collector drivers of the key and restart pins
// Assumes: pins pulled up inside the device
// Notes:   sink high pulls the pin low, never drives it high
`timescale 1ns/1ps
module mpks_host_model (
    // clock
    input wire logic clk_sys,
    // open-collector sinks
    output logic     keySink,
    output logic     rstSink
);
    initial keySink = 1'b0;
    initial rstSink = 1'b0;
    task automatic keyPulse(input int n);
        @(posedge clk_sys);
        keySink <= 1'b1;
        repeat (n) @(posedge clk_sys);
        keySink <= 1'b0;
    endtask
    task automatic rstPulse(input int n);
        @(posedge clk_sys);
        rstSink <= 1'b1;
        repeat (n) @(posedge clk_sys);
        rstSink <= 1'b0;
    endtask
endmodule

/* File: tb/mpks_module_power_key_sequencer_tb.sv */
// Purpose: self-checking bench for the power key sequencer
// Assumes: shortened counts 20, 40, 10, 5, 5
// Notes:   pull-ups resolved here from the sinks
`timescale 1ns/1ps
module mpks_module_power_key_sequencer_tb;
    localparam int OnC = 20;
    localparam int OffC = 40;
    logic       clk_sys = 1'b0;
    logic       rstn = 1'b0;
    logic       swOffReq = 1'b0;
    logic       levelWrite = 1'b0;
    logic [2:0] levelValue = 3'h1;
    logic       wakeEvent = 1'b0;
    logic       rtsLine = 1'b0;
    wire        keySink, rstSink, keyOut, keyOeN, mon, det, rf, reg_, sv, cmd;
    wire  [2:0] lvl;
    wire        powerKeyN = !keySink && (keyOeN || keyOut);
    wire        restartN = !rstSink;
    int         fails = 0;
    int         cmp_count = 0;
    always #5 clk_sys = ~clk_sys;
    mpks_module_power_key_sequencer #(.ON_CYC(32'd20), .OFF_CYC(32'd40), .RST_CYC(32'd10),
        .BOOT_CYC(32'd5), .DETACH_CYC(32'd5)) mpks_module_power_key_sequencer_inst (
        .clk_sys(clk_sys), .rstn(rstn), .powerKeyN(powerKeyN), .powerKeyOut(keyOut),
        .powerKeyOeN(keyOeN), .restartN(restartN), .swOffReq(swOffReq),
        .levelWrite(levelWrite), .levelValue(levelValue), .wakeEvent(wakeEvent),
        .rtsLine(rtsLine), .power_state_monitor(mon), .detachReq(det), .rfEnable(rf),
        .registered(reg_), .powerSave(sv), .cmdAccept(cmd), .function_level_setting(lvl));
    mpks_host_model mpks_host_model_inst (.clk_sys(clk_sys), .keySink(keySink),
        .rstSink(rstSink));
    task automatic chk(input string nm, input logic [2:0] seen, input logic [2:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic waitMon(input logic v);
        for (int i = 0; i < 300 && mon !== v; i++) @(posedge clk_sys);
        #1;
    endtask
    task automatic setLvl(input logic [2:0] v);
        @(posedge clk_sys);
        levelWrite <= 1'b1;
        levelValue <= v;
        @(posedge clk_sys);
        levelWrite <= 1'b0;
        tick(2);
    endtask
    task automatic powerOn;
        mpks_host_model_inst.keyPulse(OnC + 2);
        waitMon(1'b1);
        chk("monitor on", mon, 3'h1);
        tick(8);
        chk("on outputs", {cmd, rf, reg_}, 3'h7);
    endtask
    task automatic t_on;
        mpks_host_model_inst.keyPulse(OnC - 3);
        tick(5);
        chk("short pulse", mon, 3'h0);
        powerOn;
        chk("level", lvl, 3'h1);
        $display("test on done");
    endtask
    task automatic t_lvl;
        setLvl(3'h4);
        chk("level 4", {rf, reg_, cmd}, 3'h1);
        setLvl(3'h5);
        chk("level 5", {sv, rf, cmd}, 3'h7);
        setLvl(3'h2);
        chk("bad level", lvl, 3'h5);
        setLvl(3'h0);
        chk("level 0", {sv, reg_, cmd}, 3'h6);
        setLvl(3'h4);
        chk("ignored", lvl, 3'h0);
        @(posedge clk_sys);
        rtsLine <= 1'b1;
        tick(3);
        chk("rts wake", lvl, 3'h1);
        @(posedge clk_sys);
        rtsLine <= 1'b0;
        setLvl(3'h0);
        @(posedge clk_sys);
        wakeEvent <= 1'b1;
        @(posedge clk_sys);
        wakeEvent <= 1'b0;
        tick(2);
        chk("event wake", lvl, 3'h1);
        $display("test levels done");
    endtask
    task automatic t_swoff;
        @(posedge clk_sys);
        swOffReq <= 1'b1;
        @(posedge clk_sys);
        swOffReq <= 1'b0;
        tick(1);
        chk("sw detach", {det, rf, mon}, 3'h5);
        waitMon(1'b0);
        chk("sw off", mon, 3'h0);
        $display("test software off done");
    endtask
    task automatic t_keyoff;
        powerOn;
        fork
            mpks_host_model_inst.keyPulse(OffC + 10);
            begin
                tick(OffC + 6);
                chk("held", {det, mon, rf}, 3'h3);
            end
        join
        tick(1);
        chk("key detach", det, 3'h1);
        waitMon(1'b0);
        chk("key off", mon, 3'h0);
        $display("test key off done");
    endtask
    task automatic t_rst;
        mpks_host_model_inst.rstPulse(12);
        waitMon(1'b1);
        chk("restart on", mon, 3'h1);
        tick(8);
        mpks_host_model_inst.rstPulse(12);
        tick(3);
        chk("rebooting", {rf, mon}, 3'h1);
        tick(8);
        chk("rebooted rf", {2'h0, rf}, 3'h1);
        chk("rebooted level", lvl, 3'h1);
        $display("test restart done");
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        t_on;
        t_lvl;
        t_swoff;
        t_keyoff;
        t_rst;
        wrap_up;
    end
    initial begin
        #100us;
        fails++;
        wrap_up;
    end
endmodule
